// file: rtl/spc_pkg.sv
// Constants shared by the serial port configuration register bank.
// Assumes an 8-bit register port driven by the serial framing engine on mclk_i.
package spc_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;

  // Register offsets.
  localparam logic [11:0] OFS_PORT_CFG  = 12'h000;
  localparam logic [11:0] OFS_PART_IDENTIFIER   = 12'h003;
  localparam logic [11:0] OFS_READBACK  = 12'h004;
  localparam logic [11:0] OFS_VER_LOW   = 12'h005;
  localparam logic [11:0] OFS_VER_HIGH  = 12'h006;

  // Field positions in the port configuration byte.
  localparam int unsigned BIT_UNIDIR    = 7;
  localparam int unsigned BIT_LSB_FIRST = 6;
  localparam int unsigned BIT_SOFT_RST  = 5;

  // Field position in the readback select byte.
  localparam int unsigned BIT_RB_ACTIVE = 0;

  // Values after reset and after a soft reset to on-chip defaults.
  localparam logic       RST_UNIDIR    = 1'b0;
  localparam logic       RST_LSB_FIRST = 1'b0;
  localparam logic       RST_RB_ACTIVE = 1'b0;
  localparam logic [7:0] RST_VER_LOW   = 8'h00;
  localparam logic [7:0] RST_VER_HIGH  = 8'h00;

  // Value of the part identifier; arbitrary, chosen for this design.
  localparam logic [7:0] PART_IDENTIFIER_VAL   = 8'h5A;

  // Soft reset sequencer states.
  typedef enum logic [2:0] {
    SPC_IDLE = 3'b001,
    SPC_DEFL = 3'b010,
    SPC_NVM  = 3'b100
  } spc_state_t;

endpackage : spc_pkg

// file: rtl/spc_pin_steer.sv
// Steers read data onto the bidirectional data pin or the separate output pin.
// Assumes tx_en_i and tx_bit_i come from the framing engine on mclk_i.
`timescale 1ns/1ps
module spc_pin_steer (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic unidir_i,
  input  wire logic tx_en_i,
  input  wire logic tx_bit_i,
  // Pins
  output logic      sdio_o,
  output logic      sdio_oe_o,
  output logic      serial_out_pin_o,
  output logic      serial_out_pin_oe_o
);

  wire drive_sdio = tx_en_i & ~unidir_i;
  wire drive_out  = tx_en_i & unidir_i;

  // The unused pin is never enabled, so the output pin floats in bidirectional mode.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sdio_o              <= 1'b0;
      sdio_oe_o           <= 1'b0;
      serial_out_pin_o    <= 1'b0;
      serial_out_pin_oe_o <= 1'b0;
    end else begin
      sdio_o              <= drive_sdio & tx_bit_i;
      sdio_oe_o           <= drive_sdio;
      serial_out_pin_o    <= drive_out & tx_bit_i;
      serial_out_pin_oe_o <= drive_out;
    end
  end

endmodule : spc_pin_steer

// file: rtl/spc_regs.sv
// Serial port configuration and identification register bank.
// Assumes a framing engine on mclk_i issues byte register reads and writes.
//
// Contract
// - Pin-mode bit clear: data pin both ways, output pin floats; set: reads on output pin.
// - SPI bit-order bit clear: MSB first, address decrements; set: LSB first, increments.
// - Bit-order bit is ignored and reads unused in I2C mode.
// - Writing one to soft reset starts it, self-clears; pin high loads nonvolatile image.
// - Soft reset with nonvolatile-select pin low loads on-chip defaults.
// - Read-only 8-bit part identifier at its address; writes have no effect.
// - Readback select bit clear returns buffer registers, set returns active registers.
// - 16-bit user version ID, low then high byte, default zero, no effect.
`timescale 1ns/1ps
module spc_regs (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // Register port from the framing engine
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic [7:0]       rdata_o,
  output logic             rvalid_o,
  // Mode and pins
  input  wire logic        i2c_mode_i,
  input  wire logic        nvm_sel_pin_i,
  input  wire logic        io_update_i,
  // Nonvolatile image load
  output logic             nvm_load_req_o,
  input  wire logic        nvm_wr_i,
  input  wire logic [11:0] nvm_addr_i,
  input  wire logic [7:0]  nvm_data_i,
  input  wire logic        nvm_done_i,
  // Configuration to the framing engine
  output logic             unidirectional_pin_select_o,
  output logic             lsb_first_o,
  output logic             addr_incr_o,
  output logic             soft_reset_busy_o,
  output logic [15:0]      user_version_o,
  // Read data serialiser
  input  wire logic        tx_en_i,
  input  wire logic        tx_bit_i,
  // Pins
  output logic             sdio_o,
  output logic             sdio_oe_o,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe_o
);

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // The select pin is asynchronous to mclk_i.
  logic nvm_sel_meta_r;
  logic nvm_sel_r;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      nvm_sel_meta_r <= 1'b0;
      nvm_sel_r      <= 1'b0;
    end else begin
      nvm_sel_meta_r <= nvm_sel_pin_i;
      nvm_sel_r      <= nvm_sel_meta_r;
    end
  end

  spc_pkg::spc_state_t state_r;
  spc_pkg::spc_state_t state_nxt;

  logic       unidir_r;
  logic       lsb_first_r;
  logic       rb_active_r;
  logic [7:0] ver_lo_buf_r;
  logic [7:0] ver_hi_buf_r;
  logic [7:0] ver_lo_act_r;
  logic [7:0] ver_hi_act_r;

  // Host writes are refused while a soft reset is being carried out.
  wire idle      = (state_r == spc_pkg::SPC_IDLE);
  wire host_wr   = wr_en_i & idle;
  wire wr_cfg    = host_wr & hit(addr_i, spc_pkg::OFS_PORT_CFG);
  wire wr_rb     = host_wr & hit(addr_i, spc_pkg::OFS_READBACK);
  wire wr_lo     = host_wr & hit(addr_i, spc_pkg::OFS_VER_LOW);
  wire wr_hi     = host_wr & hit(addr_i, spc_pkg::OFS_VER_HIGH);
  wire start_rst = wr_cfg & wdata_i[spc_pkg::BIT_SOFT_RST];
  wire in_nvm    = (state_r == spc_pkg::SPC_NVM);
  wire in_defl   = (state_r == spc_pkg::SPC_DEFL);
  wire nvm_cfg   = in_nvm & nvm_wr_i & hit(nvm_addr_i, spc_pkg::OFS_PORT_CFG);
  wire nvm_rb    = in_nvm & nvm_wr_i & hit(nvm_addr_i, spc_pkg::OFS_READBACK);
  wire nvm_lo    = in_nvm & nvm_wr_i & hit(nvm_addr_i, spc_pkg::OFS_VER_LOW);
  wire nvm_hi    = in_nvm & nvm_wr_i & hit(nvm_addr_i, spc_pkg::OFS_VER_HIGH);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      spc_pkg::SPC_IDLE: begin
        if (start_rst) begin
          state_nxt = nvm_sel_r ? spc_pkg::SPC_NVM : spc_pkg::SPC_DEFL;
        end
      end
      spc_pkg::SPC_DEFL: begin
        state_nxt = spc_pkg::SPC_IDLE;
      end
      spc_pkg::SPC_NVM: begin
        if (nvm_done_i) begin
          state_nxt = spc_pkg::SPC_IDLE;
        end
      end
      default: begin
        state_nxt = spc_pkg::SPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= spc_pkg::SPC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Only bits 7 and 6 are stored; the mirror nibble is rebuilt on read.
  // A default reload outranks everything. Host and image writes never meet, because the
  // host is refused outside the idle state and the image only streams during a load.
  wire       cfg_load      = wr_cfg | nvm_cfg;
  wire       rb_load       = wr_rb | nvm_rb;
  wire [7:0] cfg_src       = nvm_cfg ? nvm_data_i : wdata_i;
  wire [7:0] rb_src        = nvm_rb ? nvm_data_i : wdata_i;
  wire       order_load    = cfg_load & ~i2c_mode_i;
  wire       unidir_nxt    = in_defl    ? spc_pkg::RST_UNIDIR :
                             cfg_load   ? cfg_src[spc_pkg::BIT_UNIDIR] :
                             unidir_r;
  wire       lsb_first_nxt = in_defl    ? spc_pkg::RST_LSB_FIRST :
                             order_load ? cfg_src[spc_pkg::BIT_LSB_FIRST] :
                             lsb_first_r;
  wire       rb_active_nxt = in_defl    ? spc_pkg::RST_RB_ACTIVE :
                             rb_load    ? rb_src[spc_pkg::BIT_RB_ACTIVE] :
                             rb_active_r;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      unidir_r    <= spc_pkg::RST_UNIDIR;
      lsb_first_r <= spc_pkg::RST_LSB_FIRST;
      rb_active_r <= spc_pkg::RST_RB_ACTIVE;
    end else begin
      unidir_r    <= unidir_nxt;
      lsb_first_r <= lsb_first_nxt;
      rb_active_r <= rb_active_nxt;
    end
  end

  // Version ID: buffer copy is written, active copy follows on an update.
  // An image load writes both copies at once, so readback agrees in either bank.
  wire       upd_act        = io_update_i & idle;
  wire [7:0] ver_lo_buf_nxt = in_defl ? spc_pkg::RST_VER_LOW :
                              nvm_lo  ? nvm_data_i :
                              wr_lo   ? wdata_i :
                              ver_lo_buf_r;
  wire [7:0] ver_hi_buf_nxt = in_defl ? spc_pkg::RST_VER_HIGH :
                              nvm_hi  ? nvm_data_i :
                              wr_hi   ? wdata_i :
                              ver_hi_buf_r;
  wire [7:0] ver_lo_act_nxt = in_defl ? spc_pkg::RST_VER_LOW :
                              nvm_lo  ? nvm_data_i :
                              upd_act ? ver_lo_buf_r :
                              ver_lo_act_r;
  wire [7:0] ver_hi_act_nxt = in_defl ? spc_pkg::RST_VER_HIGH :
                              nvm_hi  ? nvm_data_i :
                              upd_act ? ver_hi_buf_r :
                              ver_hi_act_r;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ver_lo_buf_r <= spc_pkg::RST_VER_LOW;
      ver_hi_buf_r <= spc_pkg::RST_VER_HIGH;
      ver_lo_act_r <= spc_pkg::RST_VER_LOW;
      ver_hi_act_r <= spc_pkg::RST_VER_HIGH;
    end else begin
      ver_lo_buf_r <= ver_lo_buf_nxt;
      ver_hi_buf_r <= ver_hi_buf_nxt;
      ver_lo_act_r <= ver_lo_act_nxt;
      ver_hi_act_r <= ver_hi_act_nxt;
    end
  end

  // Read decode. The soft reset bit reads one only while the reset runs.
  wire       sel_cfg    = hit(addr_i, spc_pkg::OFS_PORT_CFG);
  wire       sel_id     = hit(addr_i, spc_pkg::OFS_PART_IDENTIFIER);
  wire       sel_rb     = hit(addr_i, spc_pkg::OFS_READBACK);
  wire       sel_lo     = hit(addr_i, spc_pkg::OFS_VER_LOW);
  wire       sel_hi     = hit(addr_i, spc_pkg::OFS_VER_HIGH);
  wire       lsb_eff    = lsb_first_r & ~i2c_mode_i;
  wire [3:0] cfg_hi     = {unidir_r, lsb_eff, ~idle, 1'b0};
  wire [7:0] cfg_rd;
  wire [7:0] lo_rd      = rb_active_r ? ver_lo_act_r : ver_lo_buf_r;
  wire [7:0] hi_rd      = rb_active_r ? ver_hi_act_r : ver_hi_buf_r;
  wire [7:0] rb_rd      = {7'h00, rb_active_r};
  wire [7:0] rd_mux     = sel_cfg ? cfg_rd :
                          sel_id  ? spc_pkg::PART_IDENTIFIER_VAL :
                          sel_rb  ? rb_rd :
                          sel_lo  ? lo_rd :
                          sel_hi  ? hi_rd : 8'h00;
  wire       rvalid_nxt = rd_en_i;
  wire [7:0] rdata_nxt  = rd_en_i ? rd_mux : rdata_o;

  // The low nibble is the high nibble reversed, so the byte reads alike in either bit order.
  assign cfg_rd[7:4] = cfg_hi;
  generate
    for (genvar m = 0; m < 4; m++) begin : g_mirror
      assign cfg_rd[m] = cfg_hi[3 - m];
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rvalid_nxt;
      rdata_o  <= rdata_nxt;
    end
  end

  // Registered copies toward the framing engine and the image loader.
  wire        busy_nxt     = (state_nxt != spc_pkg::SPC_IDLE);
  wire        load_req_nxt = start_rst & nvm_sel_r;
  wire [15:0] version_nxt  = {ver_hi_act_r, ver_lo_act_r};

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      unidirectional_pin_select_o <= spc_pkg::RST_UNIDIR;
      lsb_first_o                 <= spc_pkg::RST_LSB_FIRST;
      addr_incr_o                 <= spc_pkg::RST_LSB_FIRST;
      soft_reset_busy_o           <= 1'b0;
      nvm_load_req_o              <= 1'b0;
      user_version_o              <= {spc_pkg::RST_VER_HIGH, spc_pkg::RST_VER_LOW};
    end else begin
      unidirectional_pin_select_o <= unidir_r;
      lsb_first_o                 <= lsb_eff;
      addr_incr_o                 <= lsb_eff;
      soft_reset_busy_o           <= busy_nxt;
      nvm_load_req_o              <= load_req_nxt;
      user_version_o              <= version_nxt;
    end
  end

  // Pin steering uses the stored mode bit directly so it tracks writes promptly.
  spc_pin_steer u_steer (
    .mclk_i              (mclk_i),
    .rst_i               (rst_i),
    .unidir_i            (unidir_r),
    .tx_en_i             (tx_en_i),
    .tx_bit_i            (tx_bit_i),
    .sdio_o              (sdio_o),
    .sdio_oe_o           (sdio_oe_o),
    .serial_out_pin_o    (serial_out_pin_o),
    .serial_out_pin_oe_o (serial_out_pin_oe_o)
  );

endmodule : spc_regs

// file: tb/spc_regs_asserts.sv
// Concurrent checks on the ports of the configuration register bank.
// Assumes it is bound into spc_regs and sees only that module's ports.
`timescale 1ns/1ps
module spc_regs_asserts (
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_i,
  // Register port
  input wire logic        wr_en_i,
  input wire logic        rd_en_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        rvalid_o,
  // Mode, reset and configuration
  input wire logic        i2c_mode_i,
  input wire logic        nvm_sel_pin_i,
  input wire logic        nvm_load_req_o,
  input wire logic        unidirectional_pin_select_o,
  input wire logic        lsb_first_o,
  input wire logic        addr_incr_o,
  input wire logic        soft_reset_busy_o,
  input wire logic [15:0] user_version_o,
  // Pins
  input wire logic        tx_en_i,
  input wire logic        tx_bit_i,
  input wire logic        sdio_o,
  input wire logic        sdio_oe_o,
  input wire logic        serial_out_pin_o,
  input wire logic        serial_out_pin_oe_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // The select pin passes a two-stage synchroniser, so it must be steady for three edges.
  sequence pin_low_s; !nvm_sel_pin_i [*3]; endsequence
  sequence pin_high_s; nvm_sel_pin_i [*3]; endsequence
  sequence sr_wr_s;
    wr_en_i && addr_i == spc_pkg::OFS_PORT_CFG && wdata_i[5] && !wdata_i[7] && !soft_reset_busy_o;
  endsequence
  rd_answer_a: assert property (rvalid_o == $past(rd_en_i)) else $error("read answer late");
  part_identifier_a: assert property (rd_en_i && addr_i == spc_pkg::OFS_PART_IDENTIFIER |=>
    rdata_o == spc_pkg::PART_IDENTIFIER_VAL) else $error("part identifier wrong");
  rb_unused_a: assert property (rd_en_i && addr_i == spc_pkg::OFS_READBACK |=>
    rdata_o[7:1] == 7'h00) else $error("unused readback bits set");
  cfg_mirror_a: assert property (rd_en_i && addr_i == spc_pkg::OFS_PORT_CFG |=>
    !rdata_o[4] && rdata_o[3:0] == {rdata_o[4], rdata_o[5], rdata_o[6], rdata_o[7]})
    else $error("port config readback not mirrored");
  order_pair_a: assert property (addr_incr_o == lsb_first_o) else $error("order bits split");
  i2c_order_a: assert property (i2c_mode_i && $past(i2c_mode_i) |-> !lsb_first_o)
    else $error("bit order active in two-wire mode");
  // The version output is a registered copy of the active bank, so it clears one edge late.
  sr_default_a: assert property (pin_low_s ##0 sr_wr_s |=> soft_reset_busy_o ##1
    !soft_reset_busy_o ##1 user_version_o == 16'h0000) else $error("default reload wrong");
  sr_image_a: assert property (pin_high_s ##0 sr_wr_s |=>
    nvm_load_req_o && soft_reset_busy_o) else $error("image load not requested");
  pin_idle_a: assert property (!tx_en_i |=> !sdio_oe_o && !serial_out_pin_oe_o)
    else $error("pin driven while idle");
  // Steering uses the stored mode bit, whose registered copy shows up one edge later.
  pin_bidir_a: assert property (tx_en_i ##1 !unidirectional_pin_select_o |-> sdio_oe_o &&
    !serial_out_pin_oe_o && sdio_o == $past(tx_bit_i)) else $error("data pin read wrong");
  pin_unidir_a: assert property (tx_en_i ##1 unidirectional_pin_select_o |->
    serial_out_pin_oe_o && !sdio_oe_o && serial_out_pin_o == $past(tx_bit_i))
    else $error("output pin read wrong");
endmodule : spc_regs_asserts
bind spc_regs spc_regs_asserts u_spc_chk (.*);

// file: tb/spc_nvm_model.sv
// Behavioural nonvolatile image loader answering the bank's load request.
// Assumes the request is a one-cycle pulse on mclk_i; WAIT sets how slow it answers.
`timescale 1ns/1ps
module spc_nvm_model #(
  parameter int unsigned WAIT = 3
) (
  // Clock and request
  input  wire logic  mclk_i,
  input  wire logic  load_req_i,
  // Image stream
  output logic        nvm_wr_o,
  output logic [11:0] nvm_addr_o,
  output logic [7:0]  nvm_data_o,
  output logic        nvm_done_o
);
  // Port config byte carries its mirrored low nibble.
  logic [11:0] img_addr [4] = '{12'h000, 12'h004, 12'h005, 12'h006};
  logic [7:0]  img_data [4] = '{8'h81, 8'h00, 8'hC3, 8'h3C};
  initial begin
    nvm_wr_o   = 1'b0;
    nvm_done_o = 1'b0;
    nvm_addr_o = 12'hFFF;
    nvm_data_o = 8'h00;
    forever begin
      @(posedge mclk_i);
      if (load_req_i) begin
        repeat (WAIT) @(posedge mclk_i);
        for (int i = 0; i < 4; i++) begin
          nvm_wr_o   <= 1'b1;
          nvm_addr_o <= img_addr[i];
          nvm_data_o <= img_data[i];
          @(posedge mclk_i);
        end
        // Released lines show junk, never the last value.
        nvm_wr_o   <= 1'b0;
        nvm_addr_o <= ~nvm_addr_o;
        nvm_data_o <= ~nvm_data_o;
        nvm_done_o <= 1'b1;
        @(posedge mclk_i);
        nvm_done_o <= 1'b0;
      end
    end
  end
endmodule : spc_nvm_model

// file: tb/tb_serial_port_config_regs.sv
// Self-checking bench for the configuration register bank.
// Assumes the loader model and the checker bind are compiled alongside.
`timescale 1ns/1ps
module tb_serial_port_config_regs;
  typedef struct packed {logic wr; logic [11:0] a; logic [7:0] d; logic [7:0] e;} spc_row_t;
  logic mclk_i = 1'b0, rst_i = 1'b1, wr_en_i = 1'b0, rd_en_i = 1'b0, io_update_i = 1'b0;
  logic i2c_mode_i = 1'b0, nvm_sel_pin_i = 1'b0, tx_en_i = 1'b0, tx_bit_i = 1'b0;
  logic [11:0] addr_i = 12'h000, nvm_addr_i;
  logic [7:0]  wdata_i = 8'h00, rdata_o, nvm_data_i;
  logic [15:0] user_version_o;
  logic rvalid_o, nvm_load_req_o, nvm_wr_i, nvm_done_i, unidirectional_pin_select_o;
  logic lsb_first_o, addr_incr_o, soft_reset_busy_o;
  logic sdio_o, sdio_oe_o, serial_out_pin_o, serial_out_pin_oe_o;
  int bad_count = 0, comparisons = 0, cycles = 0;
  spc_row_t rows [9] = '{'{1'b0, 12'h003, 8'h00, 8'h5A}, '{1'b1, 12'h003, 8'hFF, 8'h5A},
    '{1'b0, 12'h005, 8'h00, 8'h00}, '{1'b1, 12'h005, 8'h12, 8'h12},
    '{1'b1, 12'h006, 8'h34, 8'h34}, '{1'b1, 12'h004, 8'hFF, 8'h01},
    '{1'b0, 12'h005, 8'h00, 8'h00}, '{1'b0, 12'h007, 8'h00, 8'h00},
    '{1'b1, 12'h000, 8'h42, 8'h42}};
  spc_regs DUT (.*);
  spc_nvm_model u_nvm (.mclk_i(mclk_i), .load_req_i(nvm_load_req_o), .nvm_wr_o(nvm_wr_i),
    .nvm_addr_o(nvm_addr_i), .nvm_data_o(nvm_data_i), .nvm_done_o(nvm_done_i));
  always #25 mclk_i = ~mclk_i;
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    wr_en_i = 1'b1;
    addr_i  = a;
    wdata_i = d;
    @(negedge mclk_i);
    wr_en_i = 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    @(negedge mclk_i);
    rd_en_i = 1'b1;
    addr_i  = a;
    @(negedge mclk_i);
    rd_en_i = 1'b0;
    chk($sformatf("rdata %h", a), {7'h00, 1'b1, e}, {7'h00, rvalid_o, rdata_o});
  endtask : rd_chk
  task automatic tx(input logic uni, input logic b);
    tx_en_i  = 1'b1;
    tx_bit_i = b;
    @(negedge mclk_i);
    tx_en_i  = 1'b0;
    chk("pins", {13'h0, ~uni, uni, b}, {13'h0, sdio_oe_o, serial_out_pin_oe_o,
      uni ? serial_out_pin_o : sdio_o});
  endtask : tx
  task automatic idle_chk;
    for (int i = 0; i < 40 && soft_reset_busy_o !== 1'b0; i++) @(negedge mclk_i);
    chk("busy", 16'h0000, {15'h0, soft_reset_busy_o});
    @(negedge mclk_i);
  endtask : idle_chk
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(negedge mclk_i);
    rst_i = 1'b0;
    chk("reset", 16'h0000, user_version_o | {10'h0, unidirectional_pin_select_o,
      lsb_first_o, soft_reset_busy_o, sdio_oe_o, serial_out_pin_oe_o, rvalid_o});
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    chk("order", 16'h0003, {14'h0, lsb_first_o, addr_incr_o});
    @(negedge mclk_i);
    io_update_i = 1'b1;
    @(negedge mclk_i);
    io_update_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    chk("version", 16'h3412, user_version_o);
    rd_chk(12'h005, 8'h12);
    i2c_mode_i = 1'b1;
    wr(12'h000, 8'h42);
    rd_chk(12'h000, 8'h00);
    chk("i2c order", 16'h0000, {14'h0, lsb_first_o, addr_incr_o});
    i2c_mode_i = 1'b0;
    tx(1'b0, 1'b1);
    wr(12'h000, 8'h81);
    tx(1'b1, 1'b0);
    wr(12'h000, 8'h24);
    idle_chk();
    chk("default version", 16'h0000, user_version_o);
    rd_chk(12'h004, 8'h00);
    nvm_sel_pin_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    wr(12'h000, 8'h24);
    idle_chk();
    chk("image", 16'h3CC3, user_version_o);
    chk("image mode", 16'h0001, {15'h0, unidirectional_pin_select_o});
    rd_chk(12'h005, 8'hC3);
    tally_and_finish();
  end
endmodule : tb_serial_port_config_regs
